// ==== tb/emp_far_side.sv ====
// far side memory model: sdram data lines and static wait line
// assumes it faces the pin outputs of emp_pins
module emp_far_side (
  // pins from the block
  input wire [31:0] dq_in,
  input wire dq_oe_in,
  // bench controls
  input wire [31:0] read_word_in,
  input wire stretch_in,
  // pins to the block
  output wire [31:0] dq_out,
  output wire wait_n_out
);
  // released bus carries the memory word
  assign dq_out = dq_oe_in ? dq_in : read_word_in;
  // memory pulls wait low to stretch
  assign wait_n_out = ~stretch_in;
endmodule // emp_far_side

// ==== tb/emp_pins_assertions.sv ====
// port checks for the external memory pin block
// assumes binding into emp_pins with its header on the include path
`include "emp_pins_regs.vh"
module emp_pins_assertions #(
  parameter RESET_SEQ_CYCLES = 16
) (
  // clock, reset and state
  input wire clk_in,
  input wire resetn_in,
  input wire runtime_reset_in,
  input wire sleep_in,
  input wire hw_reset_out,
  // sdram side
  input wire [2:0] ctl_sdram_cmd_in,
  input wire [1:0] ctl_sdram_cs_in,
  input wire [3:0] ctl_sdram_lane_en_in,
  input wire [5:0] sdram_cs_mode_in,
  input wire sdram_data_bus_oe_out,
  input wire [3:0] sdram_byte_mask_n_out,
  input wire row_strobe_n_out,
  input wire column_strobe_n_out,
  input wire sdram_write_strobe_n_out,
  input wire [2:0] memory_clock_out,
  input wire [2:0] sdram_chip_select_n_out,
  input wire sdram_clock_enable_out,
  // static side
  input wire [3:0] ctl_static_cs_in,
  input wire [3:0] static_cs_card_in,
  input wire [3:0] static_cs_lcd_in,
  input wire static_wait_en_in,
  input wire static_wait_n_in,
  input wire static_stall_out,
  input wire [3:0] static_chip_select_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire quiet = hw_reset_out | runtime_reset_in | sleep_in;
  wire [2:0] strobes = {row_strobe_n_out, column_strobe_n_out,
    sdram_write_strobe_n_out};
  sequence s_activate;
    !quiet && ctl_sdram_cmd_in == `EMP_CMD_ACTIVE && ctl_sdram_cs_in == 2'h1;
  endsequence
  sequence s_sdram_run;
    sdram_cs_mode_in[1:0] == `EMP_CS_SDRAM && !hw_reset_out && !sleep_in;
  endsequence
  sequence s_rom_run;
    sdram_cs_mode_in[3:2] == `EMP_CS_SYNC_MASK_ROM && !hw_reset_out && !sleep_in;
  endsequence
  chk_quiet_idle:
  assert property ($past(quiet) |-> sdram_byte_mask_n_out == 4'hF &&
    strobes == 3'h7 && sdram_chip_select_n_out == 3'h7)
    else $error("pins not idle while quiet");
  chk_clock_low:
  assert property ($past(hw_reset_out | sleep_in) |-> memory_clock_out == 3'h0)
    else $error("memory clock running in reset or sleep");
  chk_data_float:
  assert property ($past((runtime_reset_in | sleep_in) & ~hw_reset_out)
    |-> !sdram_data_bus_oe_out) else $error("data bus driven");
  chk_sleep_cke:
  assert property ($past(sleep_in & ~runtime_reset_in & ~hw_reset_out)
    |-> !sdram_clock_enable_out) else $error("clock enable high in sleep");
  chk_cmd_walk:
  assert property (s_activate |=> strobes == 3'h3 &&
    sdram_chip_select_n_out == 3'h5) else $error("activate encoding wrong");
  chk_lane_masks:
  assert property (!quiet |=> sdram_byte_mask_n_out ==
    ~$past(ctl_sdram_lane_en_in)) else $error("byte mask lane wrong");
  chk_card_select:
  assert property (!quiet |=> static_chip_select_out ==
    ~$past(ctl_static_cs_in & ~static_cs_card_in)) else $error("rcs wrong");
  chk_wait_stall:
  assert property (static_stall_out |-> static_wait_en_in &&
    (ctl_static_cs_in & (static_cs_card_in | static_cs_lcd_in)) == 4'h0 &&
    $past(!static_wait_n_in, 2)) else $error("stall without wait");
  chk_sdram_clock:
  assert property (s_sdram_run [*3] |-> memory_clock_out[0] !=
    $past(memory_clock_out[0])) else $error("sdram clock not half rate");
  chk_rom_clock:
  assert property (s_rom_run [*5] |-> memory_clock_out[1] !=
    $past(memory_clock_out[1], 2)) else $error("rom clock not quarter rate");
endmodule // emp_pins_assertions

// ==== tb/tb_emp_pins.sv ====
// self-checking bench for the external memory pin block
// assumes emp_pins, the far side model and the checker are compiled first
`include "emp_pins_regs.vh"
module tb_emp_pins;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, resetn_in = 0, pin_n = 0, core_on = 0, rt = 0, slp = 0;
  logic io_ok = 0, ccke = 1, sboot;
  logic [31:0] saddr = 32'h0;
  wire [31:0] static_address_bus;
  logic woe = 0, wen = 0, creg = 1, cwr = 1, g6o = 1, g6oe = 1, stretch = 0;
  logic [31:0] wdata = 32'h0, rd_word = 32'hA5C30F96;
  logic [3:0] lanes = 0, slanes = 0, scs = 0, card = 0, lcd = 0, fsel = 0;
  logic [3:0] gout = 4'h5, goe = 4'hA;
  logic [2:0] cmd = 0;
  logic [1:0] cs = 3, cen = 3;
  wire [31:0] rdata, dq_o, dq_i;
  wire [3:0] bm, static_chip_select, static_byte_enable_n, pins, pins_oe;
  wire [2:0] mclk, sdram_chip_select_n;
  wire dq_oe, ras, cas, we, cke, stall, wait_n, g6, g6_oe, hwr;
  int mismatches = 0, n_tests = 0, n, i;
  logic [5:0] rows [8] = '{6'h07, 6'h0B, 6'h15, 6'h1C, 6'h22, 6'h29, 6'h30,
    6'h3E};
  always #20 clk_in = ~clk_in;
  emp_pins #(.RESET_SEQ_CYCLES(8)) u_emp_pins (.clk_in(clk_in),
    .resetn_in(resetn_in), .io_supply_good_in(io_ok), .core_supply_in(core_on),
    .reset_input_n_in(pin_n), .runtime_reset_in(rt), .sleep_in(slp),
    .boot_device_strap_in(1'b0), .boot_width_strap_in(2'h0),
    .ctl_sdram_wdata_in(wdata), .ctl_sdram_wdata_oe_in(woe),
    .ctl_sdram_lane_en_in(lanes), .ctl_sdram_cmd_in(cmd),
    .ctl_sdram_cs_in(cs), .ctl_sdram_cke_in(ccke), .ctl_sync_mask_rom_cke_in(1'b1),
    .sdram_cs_mode_in(6'h09), .sdram_rdata_out(rdata),
    .sdram_data_bus_in(dq_i), .sdram_data_bus_out(dq_o),
    .sdram_data_bus_oe_out(dq_oe), .sdram_byte_mask_n_out(bm),
    .row_strobe_n_out(ras), .column_strobe_n_out(cas),
    .sdram_write_strobe_n_out(we), .memory_clock_out(mclk),
    .sdram_chip_select_n_out(sdram_chip_select_n), .sdram_clock_enable_out(cke),
    .ctl_static_lane_en_in(slanes), .ctl_static_cs_in(scs),
    .static_cs_card_in(card), .static_cs_lcd_in(lcd),
    .static_wait_en_in(wen), .ctl_static_addr_in(saddr),
    .static_stall_out(stall), .static_wait_n_in(wait_n),
    .static_address_bus_out(static_address_bus), .static_byte_enable_n_out(static_byte_enable_n),
    .static_chip_select_out(static_chip_select), .ctl_card_reg_n_in(creg),
    .ctl_card_enable_n_in(cen), .ctl_card_write_n_in(cwr),
    .card_func_sel_in(fsel), .gpio_card_out_in(gout), .gpio_card_oe_in(goe),
    .gpio_six_out_in(g6o), .gpio_six_oe_in(g6oe), .card_pins_out(pins),
    .card_pins_oe_out(pins_oe), .gpio_pin_six_out(g6),
    .gpio_pin_six_oe_out(g6_oe), .hw_reset_out(hwr), .sync_mask_rom_boot_out(sboot));
  emp_far_side u_emp_far_side (.dq_in(dq_o), .dq_oe_in(dq_oe),
    .read_word_in(rd_word), .stretch_in(stretch), .dq_out(dq_i),
    .wait_n_out(wait_n));
  task automatic tick(input int k = 1);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic edges(input int b, output int c);
    logic p;
    c = 0;
    repeat (8) begin
      p = mclk[b];
      tick();
      c += int'(mclk[b] !== p);
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    finish_test();
  end
  initial begin
    tick(3);
    resetn_in = 1;
    tick(4);
    chk("dq_oe", 0, dq_oe);
    io_ok = 1;
    tick(3);
    chk("dq_oe good", 1, dq_oe);
    core_on = 1;
    tick(3);
    chk("dq_oe core", 0, dq_oe);
    pin_n = 1;
    tick(4);
    chk("dq_oe", 1, dq_oe);
    chk("dq", 0, dq_o);
    for (i = 0; i < 40 && hwr !== 1'b0; i++) tick();
    chk("hw_reset", 0, hwr);
    for (i = 0; i < 8; i++) begin
      cmd = rows[i][5:3];
      cs = i % 4;
      lanes = i;
      slanes = ~i[3:0];
      scs = 4'h1 << (i % 4);
      card = i;
      saddr = {8{i[3:0]}};
      ccke = i[0];
      woe = i[1] & ~i[2];
      wdata = {4{rows[i], 2'h3}};
      tick();
      chk("rad", saddr, static_address_bus);
      chk("cke", ccke, cke);
      chk("dq_oe run", woe, dq_oe);
      chk("dq", wdata, dq_o);
      chk("strobes", rows[i][2:0], {ras, cas, we});
      chk("sdram_chip_select_n", cs == 3 ? 3'h7 : 3'(~(3'h1 << cs)), sdram_chip_select_n);
      chk("mask", 4'(~lanes), bm);
      chk("static_byte_enable_n", 4'(~slanes), static_byte_enable_n);
      chk("rcs", 4'(~(scs & ~card)), static_chip_select);
    end
    tick(2);
    chk("rdata", rd_word, rdata);
    chk("gpio six", {g6oe, g6o}, {g6_oe, g6});
    chk("boot", 0, sboot);
    edges(0, n);
    chk("sdram clock", 8, n);
    edges(1, n);
    chk("rom clock", 4, n);
    {wen, card, scs, stretch} = {1'b1, 4'h0, 4'h1, 1'b1};
    tick(3);
    chk("stall", 1, stall);
    lcd = 4'h1;
    #1;
    chk("stall lcd", 0, stall);
    {fsel, creg, cen, cwr} = {4'hF, 1'b0, 2'h1, 1'b0};
    tick(3);
    chk("card pins", 4'h2, pins);
    chk("card oe", 4'hF, pins_oe);
    rt = 1;
    saddr = 32'h0;
    tick(3);
    chk("rt rad", 32'h77777777, static_address_bus);
    chk("rt pins", {goe, gout}, {pins_oe, pins});
    chk("rt idle", 11'h7FF, {bm, ras, cas, we, sdram_chip_select_n, cke});
    chk("rt dq_oe", 0, dq_oe);
    edges(0, n);
    chk("rt clock", 8, n);
    {rt, slp} = 2'h1;
    tick(2);
    chk("sleep", 4'h0, {mclk, cke});
    finish_test();
  end
endmodule // tb_emp_pins

bind emp_pins emp_pins_assertions #(.RESET_SEQ_CYCLES(RESET_SEQ_CYCLES))
  u_emp_pins_assertions (.*);

// ==== verilog/emp_pins.v ====
// external memory pin state and multiplexing for sdram and static bus
// assumes controller inputs on clk_in; pin inputs are synchronised here
//
// Contract
// - sdram data floats under reset pin with core power or without io supply good, else low in hardware reset, and floats in runtime reset and sleep.
// - sdram byte masks are active low, mask writes and enable reads, and sit high in every reset and sleep.
// - mask bit n covers sdram data byte lane n.
// - row, column and write strobes with the chip select carry the command and sit high in every reset and sleep.
// - each sdram chip select has its own clock at half bus rate for sdram and a quarter for mask rom.
// - memory clocks are low in hardware reset and sleep but keep running in runtime reset.
// - sdram chip selects are active low and high in resets and sleep; clock enable is high in resets and low in sleep.
// - the gpio six pin carries the mask rom clock enable only when the straps pick mask rom boot.
// - static byte enables are active low with enable n on data byte lane n.
// - a static chip select stays idle for a region set up as a card.
// - the active low wait input stretches an access only when enabled and never for lcd or card regions.
// - the card register space select is active low and gpio owns its pin out of any reset or sleep.
// - the two card enables are active low and gpio owns their pins out of any reset or sleep.
// - gpio owns the card write enable pin out of any reset or sleep until it is handed to the card logic.
`include "emp_pins_regs.vh"

module emp_pins #(
  parameter RESET_SEQ_CYCLES = `EMP_RESET_SEQ_CYCLES
) (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // power and reset pins
  input wire io_supply_good_in,
  input wire core_supply_in,
  input wire reset_input_n_in,
  input wire runtime_reset_in,
  input wire sleep_in,
  input wire boot_device_strap_in,
  input wire [1:0] boot_width_strap_in,
  // sdram controller side
  input wire [31:0] ctl_sdram_wdata_in,
  input wire ctl_sdram_wdata_oe_in,
  input wire [3:0] ctl_sdram_lane_en_in,
  input wire [2:0] ctl_sdram_cmd_in,
  input wire [1:0] ctl_sdram_cs_in,
  input wire ctl_sdram_cke_in,
  input wire ctl_sync_mask_rom_cke_in,
  input wire [5:0] sdram_cs_mode_in,
  output wire [31:0] sdram_rdata_out,
  // sdram pins
  input wire [31:0] sdram_data_bus_in,
  output wire [31:0] sdram_data_bus_out,
  output wire sdram_data_bus_oe_out,
  output wire [3:0] sdram_byte_mask_n_out,
  output wire row_strobe_n_out,
  output wire column_strobe_n_out,
  output wire sdram_write_strobe_n_out,
  output wire [2:0] memory_clock_out,
  output wire [2:0] sdram_chip_select_n_out,
  output wire sdram_clock_enable_out,
  // static controller side
  input wire [3:0] ctl_static_lane_en_in,
  input wire [3:0] ctl_static_cs_in,
  input wire [3:0] static_cs_card_in,
  input wire [3:0] static_cs_lcd_in,
  input wire static_wait_en_in,
  input wire [31:0] ctl_static_addr_in,
  output wire static_stall_out,
  // static pins
  input wire static_wait_n_in,
  output wire [31:0] static_address_bus_out,
  output wire [3:0] static_byte_enable_n_out,
  output wire [3:0] static_chip_select_out,
  // card controller side and gpio function
  input wire ctl_card_reg_n_in,
  input wire [1:0] ctl_card_enable_n_in,
  input wire ctl_card_write_n_in,
  input wire [3:0] card_func_sel_in,
  input wire [3:0] gpio_card_out_in,
  input wire [3:0] gpio_card_oe_in,
  input wire gpio_six_out_in,
  input wire gpio_six_oe_in,
  // shared pins
  output wire [3:0] card_pins_out,
  output wire [3:0] card_pins_oe_out,
  output wire gpio_pin_six_out,
  output wire gpio_pin_six_oe_out,
  // state
  output wire hw_reset_out,
  output wire sync_mask_rom_boot_out
);

  localparam [15:0] SEQ_LAST = RESET_SEQ_CYCLES - 1;

  // ----------------------------------------------------------------
  // command encoding, returns {row, column, write} active low
  // ----------------------------------------------------------------
  function [2:0] emp_strobes;
    input [2:0] cmd;
    begin
      case (cmd)
        `EMP_CMD_ACTIVE: emp_strobes = 3'h3;
        `EMP_CMD_READ: emp_strobes = 3'h5;
        `EMP_CMD_WRITE: emp_strobes = 3'h4;
        `EMP_CMD_PRECHARGE: emp_strobes = 3'h2;
        `EMP_CMD_REFRESH: emp_strobes = 3'h1;
        `EMP_CMD_LOAD_MODE: emp_strobes = 3'h0;
        `EMP_CMD_BURST_STOP: emp_strobes = 3'h6;
        default: emp_strobes = 3'h7;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  reg [5:0] pin_s1_q;
  reg [5:0] pin_s2_q;
  reg wait_s1_q;
  reg wait_s2_q;
  reg [31:0] rd_s1_q;
  reg [31:0] rd_s2_q;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      wait_s1_q <= 1'h1;
      wait_s2_q <= 1'h1;
      rd_s1_q <= 32'h00000000;
      rd_s2_q <= 32'h00000000;
    end else begin
      pin_s1_q <= {reset_input_n_in, core_supply_in, io_supply_good_in,
                   boot_device_strap_in, boot_width_strap_in};
      pin_s2_q <= pin_s1_q;
      wait_s1_q <= static_wait_n_in;
      wait_s2_q <= wait_s1_q;
      rd_s1_q <= sdram_data_bus_in;
      rd_s2_q <= rd_s1_q;
    end
  end

  wire rst_pin_n = pin_s2_q[5];
  wire core_on = pin_s2_q[4];
  wire io_good = pin_s2_q[3];
  wire strap_dev = pin_s2_q[2];
  wire [1:0] strap_width = pin_s2_q[1:0];

  // ----------------------------------------------------------------
  // hardware reset sequence and strap capture
  // ----------------------------------------------------------------
  reg [15:0] seq_cnt_q;
  reg seq_done_q;
  reg sync_mask_rom_boot_q;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seq_cnt_q <= 16'h0000;
      seq_done_q <= 1'h0;
      sync_mask_rom_boot_q <= 1'h0;
    end else if (!rst_pin_n) begin
      seq_cnt_q <= 16'h0000;
      seq_done_q <= 1'h0;
    end else if (!seq_done_q) begin
      if (seq_cnt_q == SEQ_LAST) begin
        seq_done_q <= 1'h1;
        sync_mask_rom_boot_q <= (strap_dev == `EMP_BOOT_DEV_SYNC_MASK_ROM) &&
                        (strap_width == `EMP_BOOT_WIDTH_SYNC_MASK_ROM);
      end else begin
        seq_cnt_q <= seq_cnt_q + 16'h0001;
      end
    end
  end

  wire hr = ~seq_done_q;
  wire rr = runtime_reset_in & ~hr;
  wire slp = sleep_in & ~hr & ~rr;
  wire quiet = hr | rr | slp;

  // ----------------------------------------------------------------
  // sdram pins
  // ----------------------------------------------------------------
  reg [1:0] div_q;
  reg [31:0] sdd_q;
  reg sdd_oe_q;
  reg [3:0] mask_n_q;
  reg [2:0] strobe_n_q;
  reg [2:0] sdram_chip_select_n_n_q;
  reg [2:0] mclk_q;
  reg cke_q;
  wire [1:0] div_d = div_q + 2'h1;
  reg [2:0] mclk_d;
  integer i;
  integer j;

  always @* begin
    mclk_d = 3'h0;
    for (i = 0; i < 3; i = i + 1) begin
      if (sdram_cs_mode_in[2*i +: 2] == `EMP_CS_SDRAM) begin
        mclk_d[i] = div_d[0];
      end else if (sdram_cs_mode_in[2*i +: 2] == `EMP_CS_SYNC_MASK_ROM) begin
        mclk_d[i] = div_d[1];
      end
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_q <= 2'h0;
      sdd_q <= 32'h00000000;
      sdd_oe_q <= 1'h0;
      mask_n_q <= `EMP_MASK_IDLE;
      strobe_n_q <= `EMP_STROBE_IDLE;
      sdram_chip_select_n_n_q <= `EMP_SDRAM_CHIP_SELECT_N_IDLE;
      mclk_q <= 3'h0;
      cke_q <= 1'h1;
    end else begin
      div_q <= div_d;
      // clocks stop in hw reset and sleep only
      mclk_q <= (hr | slp) ? 3'h0 : mclk_d;
      if (hr) begin
        sdd_q <= 32'h00000000;
        sdd_oe_q <= !(!rst_pin_n && core_on) && (io_good || rst_pin_n);
      end else if (rr | slp) begin
        sdd_oe_q <= 1'h0;
      end else begin
        sdd_q <= ctl_sdram_wdata_in;
        sdd_oe_q <= ctl_sdram_wdata_oe_in;
      end
      // clock enable high in resets, low in sleep
      cke_q <= slp ? 1'h0 : ((hr | rr) ? 1'h1 : ctl_sdram_cke_in);
      if (quiet) begin
        mask_n_q <= `EMP_MASK_IDLE;
        strobe_n_q <= `EMP_STROBE_IDLE;
        sdram_chip_select_n_n_q <= `EMP_SDRAM_CHIP_SELECT_N_IDLE;
      end else begin
        // mask bit n on byte lane n
        mask_n_q <= ~ctl_sdram_lane_en_in;
        strobe_n_q <= emp_strobes(ctl_sdram_cmd_in);
        sdram_chip_select_n_n_q <= (ctl_sdram_cs_in == 2'h3) ? `EMP_SDRAM_CHIP_SELECT_N_IDLE :
                    ~(3'h1 << ctl_sdram_cs_in);
      end
    end
  end

  // ----------------------------------------------------------------
  // static bus pins
  // ----------------------------------------------------------------
  reg [31:0] rad_q;
  reg [3:0] static_byte_enable_n_n_q;
  reg [3:0] rcs_q;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rad_q <= 32'h00000000;
      static_byte_enable_n_n_q <= `EMP_MASK_IDLE;
      rcs_q <= `EMP_RCS_IDLE;
    end else if (hr) begin
      rad_q <= 32'h00000000;
      static_byte_enable_n_n_q <= `EMP_MASK_IDLE;
      rcs_q <= `EMP_RCS_IDLE;
    end else if (rr | slp) begin
      static_byte_enable_n_n_q <= `EMP_MASK_IDLE;
      rcs_q <= `EMP_RCS_IDLE;
    end else begin
      rad_q <= ctl_static_addr_in;
      static_byte_enable_n_n_q <= ~ctl_static_lane_en_in;
      rcs_q <= ~(ctl_static_cs_in & ~static_cs_card_in);
    end
  end

  // wait only for enabled plain regions
  assign static_stall_out = ~quiet & static_wait_en_in & ~wait_s2_q &
    (|(ctl_static_cs_in & ~(static_cs_lcd_in | static_cs_card_in)));

  // ----------------------------------------------------------------
  // shared gpio pins
  // ----------------------------------------------------------------
  reg [3:0] card_func_q;
  reg [3:0] card_pin_q;
  reg [3:0] card_oe_q;
  reg g6_q;
  reg g6_oe_q;
  wire [3:0] card_val = {ctl_card_write_n_in, ctl_card_enable_n_in,
                         ctl_card_reg_n_in};

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      card_func_q <= 4'h0;
      card_pin_q <= 4'h0;
      card_oe_q <= 4'h0;
      g6_q <= 1'h0;
      g6_oe_q <= 1'h0;
    end else begin
      // gpio owns register select out of reset
      // gpio owns card enables out of reset
      // gpio owns write enable until handed over
      card_func_q <= quiet ? 4'h0 : card_func_sel_in;
      for (j = 0; j < 4; j = j + 1) begin
        card_pin_q[j] <= card_func_q[j] ? card_val[j] : gpio_card_out_in[j];
        card_oe_q[j] <= card_func_q[j] | gpio_card_oe_in[j];
      end
      // mask rom enable owns pin on rom boot
      g6_q <= sync_mask_rom_boot_q ? ctl_sync_mask_rom_cke_in : gpio_six_out_in;
      g6_oe_q <= sync_mask_rom_boot_q | gpio_six_oe_in;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sdram_rdata_out = rd_s2_q;
  assign sdram_data_bus_out = sdd_q;
  assign sdram_data_bus_oe_out = sdd_oe_q;
  assign sdram_byte_mask_n_out = mask_n_q;
  assign row_strobe_n_out = strobe_n_q[2];
  assign column_strobe_n_out = strobe_n_q[1];
  assign sdram_write_strobe_n_out = strobe_n_q[0];
  assign memory_clock_out = mclk_q;
  assign sdram_chip_select_n_out = sdram_chip_select_n_n_q;
  assign sdram_clock_enable_out = cke_q;
  assign static_address_bus_out = rad_q;
  assign static_byte_enable_n_out = static_byte_enable_n_n_q;
  assign static_chip_select_out = rcs_q;
  assign card_pins_out = card_pin_q;
  assign card_pins_oe_out = card_oe_q;
  assign gpio_pin_six_out = g6_q;
  assign gpio_pin_six_oe_out = g6_oe_q;
  assign hw_reset_out = hr;
  assign sync_mask_rom_boot_out = sync_mask_rom_boot_q;

endmodule // emp_pins

// ==== verilog/emp_pins_regs.vh ====
// constants for the external memory pin block
// assumes a single 25 MHz system bus clock and plain-port control
`ifndef EMP_PINS_REGS_VH
`define EMP_PINS_REGS_VH

// ----------------------------------------------------------------
// sdram command codes on ctl_sdram_cmd_in
// ----------------------------------------------------------------
`define EMP_CMD_NOP 3'h0
`define EMP_CMD_ACTIVE 3'h1
`define EMP_CMD_READ 3'h2
`define EMP_CMD_WRITE 3'h3
`define EMP_CMD_PRECHARGE 3'h4
`define EMP_CMD_REFRESH 3'h5
`define EMP_CMD_LOAD_MODE 3'h6
`define EMP_CMD_BURST_STOP 3'h7

// ----------------------------------------------------------------
// per chip select mode, two bits each on sdram_cs_mode_in
// ----------------------------------------------------------------
`define EMP_CS_OFF 2'h0
`define EMP_CS_SDRAM 2'h1
`define EMP_CS_SYNC_MASK_ROM 2'h2
`define EMP_CS_NONE 2'h3

// ----------------------------------------------------------------
// straps that choose boot from sync mask rom
// ----------------------------------------------------------------
`define EMP_BOOT_DEV_SYNC_MASK_ROM 1'h1
`define EMP_BOOT_WIDTH_SYNC_MASK_ROM 2'h1

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define EMP_MASK_IDLE 4'hF
`define EMP_STROBE_IDLE 3'h7
`define EMP_SDRAM_CHIP_SELECT_N_IDLE 3'h7
`define EMP_RCS_IDLE 4'hF
`define EMP_RESET_SEQ_CYCLES 16

// ----------------------------------------------------------------
// bit positions in the shared card / gpio pin group
// ----------------------------------------------------------------
`define EMP_PIN_204 0
`define EMP_PIN_205 1
`define EMP_PIN_206 2
`define EMP_PIN_207 3

`endif
